// >>> core/tmc_core.sv
// Purpose: common timer core: counter, comparators, interrupts, output pins
// Assumes: register port strobes are one cycle, read data one cycle later
// Notes:   timer type parameter fixes counter width and comparator set
`include "tmc_defines.svh"

module tmc_core
  import tmc_pkg::*;
#(
  parameter tmc_type_e TM_TYPE = TMC_ENHANCED
) (
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  input  wire logic                     high_clk_tick,
  input  wire logic                     time_base_tick,
  input  wire logic                     external_count_input,
  input  wire logic [`TMC_AW-1:0]       reg_addr,
  input  wire logic [`TMC_DW-1:0]       reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [`TMC_DW-1:0]       reg_rdata_q,
  output logic                          irq_q,
  output logic      [`TMC_NPIN-1:0]     timer_output_pin_q,
  output logic      [`TMC_NPIN-1:0]     timer_output_pin_oe_n_q,
  output logic      [`TMC_NPIN-1:0]     timer_pin_select_q
);

  // ------------------------------------------------------------
  // width and comparator set
  // ------------------------------------------------------------
  localparam logic [`TMC_CW-1:0] CNT_MASK =
    (TM_TYPE == TMC_STANDARD) ? 16'hFFFF : 16'h03FF; // RULE12
  localparam logic HAS_B = (TM_TYPE == TMC_ENHANCED); // RULE3 RULE4

  logic [`TMC_DW-1:0]     ctrl0_q;
  logic [`TMC_DW-1:0]     ctrl1_q;
  logic [`TMC_CW-1:0]     cmpa_q;
  logic [`TMC_CW-1:0]     cmpb_q;
  logic [`TMC_CW-1:0]     cmpp_q;
  logic [`TMC_CW-1:0]     count_q;
  logic [`TMC_NIRQ-1:0]   status_q;
  logic [`TMC_NIRQ-1:0]   mask_q;
  logic [`TMC_NPIN-1:0]   pinen_q;
  logic [`TMC_NPIN-1:0]   portdat_q;
  logic                   out_lvl_q;
  logic [3:0]             pre_q;
  logic [1:0]             hpre_q;
  logic [3:0]             hdiv_q;

  logic [2:0]             ck_sel;
  logic                   run;
  tmc_mode_e              mode;
  tmc_act_e               act;
  tmc_act_e               act_b;
  logic                   pin_edge;
  logic                   tick;
  logic                   match_a;
  logic                   match_b;
  logic                   match_p;
  logic [`TMC_NIRQ-1:0]   events;
  logic [`TMC_NIRQ-1:0]   w1c;
  logic                   clr_cnt;
  logic                   out_lvl_d;

  assign ck_sel = ctrl0_q[`TMC_CK_MSB:`TMC_CK_LSB];
  assign run    = ctrl0_q[`TMC_RUN_BIT];
  assign mode   = tmc_mode_e'(ctrl1_q[`TMC_MODE_MSB:`TMC_MODE_LSB]);
  assign act    = tmc_act_e'(ctrl1_q[`TMC_ACT_MSB:`TMC_ACT_LSB]);
  assign act_b  = tmc_act_e'(ctrl1_q[`TMC_ACTB_MSB:`TMC_ACTB_LSB]);

  // ------------------------------------------------------------
  // external input
  // ------------------------------------------------------------
  tmc_sync_edge u_pin_sync (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .pin_async   (external_count_input),
    .falling_sel (ctrl0_q[`TMC_EDGE_BIT]),
    .edge_pulse  (pin_edge)
  );

  // ------------------------------------------------------------
  // clock prescalers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= 4'h0;
    end else begin
      pre_q <= pre_q + 4'h1;
    end
  end

  // high clock arrives as a one-cycle tick from the clock unit
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hdiv_q <= 4'h0;
    end else if (high_clk_tick) begin
      hdiv_q <= hdiv_q + 4'h1;
    end
  end

  // second stage turns the divide-by-16 wrap into divide-by-64
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hpre_q <= 2'h0;
    end else if (high_clk_tick && (hdiv_q == `TMC_DIV_HIGH16)) begin
      hpre_q <= hpre_q + 2'h1;
    end
  end

  always_comb begin
    case (ck_sel) // RULE1
      `TMC_CK_SYS4:     tick = (pre_q[1:0] == 2'(`TMC_DIV_SYS4));
      `TMC_CK_SYS:      tick = 1'b1;
      `TMC_CK_HIGH16:   tick = high_clk_tick && (hdiv_q == `TMC_DIV_HIGH16);
      `TMC_CK_HIGH64:   tick = high_clk_tick && (hdiv_q == `TMC_DIV_HIGH16)
                               && (hpre_q == `TMC_HIGH64_CNT);
      `TMC_CK_TBC:      tick = time_base_tick;
      `TMC_CK_RESERVED: tick = 1'b0; // RULE2
      `TMC_CK_PIN_RISE: tick = pin_edge; // RULE7
      `TMC_CK_PIN_ALT:  tick = pin_edge; // RULE7
      default:          tick = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // counter and comparators
  // ------------------------------------------------------------
  // a stopped timer holds its counter at zero; without the run gate a
  // zero compare value would keep raising events while stopped
  assign match_a = run && tick && (count_q == cmpa_q); // RULE5
  assign match_b = HAS_B && run && tick && (count_q == cmpb_q); // RULE4
  assign match_p = run && tick && (count_q == cmpp_q); // RULE5
  assign events  = {match_p, match_b, match_a};

  assign clr_cnt = (match_p && ctrl1_q[`TMC_CLRP_BIT]) ||
                   (match_a && ctrl1_q[`TMC_CLRA_BIT]); // RULE5

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= '0;
    end else if (!run) begin
      count_q <= '0;
    end else if (clr_cnt) begin
      count_q <= '0;
    end else if (tick) begin
      count_q <= (count_q + 16'h0001) & CNT_MASK; // RULE14 RULE12
    end
  end

  // ------------------------------------------------------------
  // output level
  // ------------------------------------------------------------
  always_comb begin
    out_lvl_d = out_lvl_q;
    case (mode)
      TMC_MODE_CMP_OUT: begin
        if (run && match_a) begin
          case (act) // RULE8
            TMC_ACT_LOW:    out_lvl_d = 1'b0;
            TMC_ACT_HIGH:   out_lvl_d = 1'b1;
            TMC_ACT_TOGGLE: out_lvl_d = ~out_lvl_q;
            default:        out_lvl_d = out_lvl_q;
          endcase
        end else if (run && match_b) begin
          case (act_b) // RULE8
            TMC_ACT_LOW:    out_lvl_d = 1'b0;
            TMC_ACT_HIGH:   out_lvl_d = 1'b1;
            TMC_ACT_TOGGLE: out_lvl_d = ~out_lvl_q;
            default:        out_lvl_d = out_lvl_q;
          endcase
        end
      end
      TMC_MODE_PWM: begin
        // edge-aligned: high from period wrap until duty match
        if (run && match_a) begin
          out_lvl_d = 1'b0; // RULE9
        end else if (run && (clr_cnt || (tick && count_q == 16'h0000))) begin
          out_lvl_d = 1'b1; // RULE9
        end
      end
      TMC_MODE_TIMER: out_lvl_d = 1'b0;
      default:        out_lvl_d = out_lvl_q;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_lvl_q <= 1'b0;
    end else begin
      out_lvl_q <= out_lvl_d;
    end
  end

  // port data bit inverts each pin, so two pins can run complementary
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_output_pin_q <= '0;
    end else begin
      timer_output_pin_q <= {`TMC_NPIN{out_lvl_d}} ^ portdat_q; // RULE11
    end
  end

  // pins drive only when enabled
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_output_pin_oe_n_q <= '1;
    end else begin
      timer_output_pin_oe_n_q <= ~pinen_q; // RULE10 RULE13
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_pin_select_q <= '0;
    end else begin
      timer_pin_select_q <= pinen_q; // RULE13
    end
  end

  // ------------------------------------------------------------
  // interrupts
  // ------------------------------------------------------------
  assign w1c = (reg_wr && reg_addr == `TMC_OFF_STATUS) ?
               reg_wdata[`TMC_NIRQ-1:0] : '0;

  // set wins over a clear in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~w1c) | events; // RULE15 RULE3
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & mask_q);
    end
  end

  // ------------------------------------------------------------
  // register port
  // ------------------------------------------------------------
  // one process per register keeps each write decode local; unmapped
  // indices simply match none of them
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl0_q <= `TMC_CTRL0_RESET;
    end else if (reg_wr && (reg_addr == `TMC_OFF_CTRL0)) begin
      ctrl0_q <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl1_q <= `TMC_CTRL1_RESET;
    end else if (reg_wr && (reg_addr == `TMC_OFF_CTRL1)) begin
      ctrl1_q <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmpa_q <= '0;
    end else if (reg_wr && (reg_addr == `TMC_OFF_CMPA)) begin
      cmpa_q <= reg_wdata & CNT_MASK;
    end
  end

  // comparator B only exists on the enhanced type
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmpb_q <= '0;
    end else if (reg_wr && (reg_addr == `TMC_OFF_CMPB)) begin
      cmpb_q <= HAS_B ? (reg_wdata & CNT_MASK) : '0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmpp_q <= '0;
    end else if (reg_wr && (reg_addr == `TMC_OFF_CMPP)) begin
      cmpp_q <= reg_wdata & CNT_MASK;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= '0;
    end else if (reg_wr && (reg_addr == `TMC_OFF_MASK)) begin
      mask_q <= reg_wdata[`TMC_NIRQ-1:0] & {1'b1, HAS_B, 1'b1};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinen_q <= `TMC_PINEN_RESET;
    end else if (reg_wr && (reg_addr == `TMC_OFF_PINEN)) begin
      pinen_q <= reg_wdata[`TMC_NPIN-1:0]; // RULE10
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      portdat_q <= '0;
    end else if (reg_wr && (reg_addr == `TMC_OFF_PORTDAT)) begin
      portdat_q <= reg_wdata[`TMC_NPIN-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        `TMC_OFF_CTRL0:   reg_rdata_q <= ctrl0_q;
        `TMC_OFF_CTRL1:   reg_rdata_q <= ctrl1_q;
        `TMC_OFF_CMPA:    reg_rdata_q <= cmpa_q;
        `TMC_OFF_CMPB:    reg_rdata_q <= cmpb_q;
        `TMC_OFF_CMPP:    reg_rdata_q <= cmpp_q;
        `TMC_OFF_COUNT:   reg_rdata_q <= count_q;
        `TMC_OFF_STATUS:  reg_rdata_q <= {13'h0000, status_q};
        `TMC_OFF_MASK:    reg_rdata_q <= {13'h0000, mask_q};
        `TMC_OFF_PINEN:   reg_rdata_q <= {14'h0000, pinen_q};
        `TMC_OFF_PORTDAT: reg_rdata_q <= {14'h0000, portdat_q};
        default:          reg_rdata_q <= '0;
      endcase
    end else begin
      reg_rdata_q <= '0;
    end
  end

endmodule : tmc_core

// >>> shared/tmc_defines.svh
// Purpose: constants for the timer module common core
// Assumes: system clock 125 MHz, one clock domain
// Notes:   register offsets and field positions of the plain register port
// What this block does
// RULE1 - clock select picks sys, high, base, pin
// RULE2 - reserved select code stops all counting
// RULE3 - compact and standard: interrupts A and P
// RULE4 - enhanced: comparators A, B, P with interrupts
// RULE5 - match raises interrupt, may clear, drive pin
// RULE6 - external input rising or falling edge selectable
// RULE7 - external input counts only when selected
// RULE8 - match output: set, clear or toggle
// RULE9 - pwm waveform on the compare output pin
// RULE10 - one enable bit per output pin
// RULE11 - port data bit inverts each output pin
// RULE12 - compact/enhanced 10 bits, standard 16 bits
// RULE13 - enable one selects timer, zero other function
// RULE14 - count one per active edge, hold reserved
// RULE15 - interrupt flags sticky until software clears
`ifndef TMC_DEFINES_SVH
`define TMC_DEFINES_SVH

`define TMC_AW            4
`define TMC_DW            16
`define TMC_CW            16
`define TMC_NPIN          2

`define TMC_OFF_CTRL0     4'h0
`define TMC_OFF_CTRL1     4'h1
`define TMC_OFF_CMPA      4'h2
`define TMC_OFF_CMPB      4'h3
`define TMC_OFF_CMPP      4'h4
`define TMC_OFF_COUNT     4'h5
`define TMC_OFF_STATUS    4'h6
`define TMC_OFF_MASK      4'h7
`define TMC_OFF_PINEN     4'h8
`define TMC_OFF_PORTDAT   4'h9

// control 0 fields
`define TMC_CK_LSB        0
`define TMC_CK_MSB        2
`define TMC_RUN_BIT       3
`define TMC_EDGE_BIT      4
// control 1 fields
`define TMC_MODE_LSB      0
`define TMC_MODE_MSB      1
`define TMC_ACT_LSB       2
`define TMC_ACT_MSB       3
`define TMC_CLRP_BIT      4
`define TMC_CLRA_BIT      5
`define TMC_ACTB_LSB      6
`define TMC_ACTB_MSB      7

// clock select codes
`define TMC_CK_SYS4       3'h0
`define TMC_CK_SYS        3'h1
`define TMC_CK_HIGH16     3'h2
`define TMC_CK_HIGH64     3'h3
`define TMC_CK_TBC        3'h4
`define TMC_CK_RESERVED   3'h5
`define TMC_CK_PIN_RISE   3'h6
`define TMC_CK_PIN_ALT    3'h7

`define TMC_DIV_SYS4      4'h3
`define TMC_DIV_HIGH16    4'hF
`define TMC_HIGH64_CNT    2'h3

// interrupt status bits
`define TMC_IRQ_A         0
`define TMC_IRQ_B         1
`define TMC_IRQ_P         2
`define TMC_NIRQ          3

`define TMC_PINEN_RESET   2'h1
`define TMC_CTRL0_RESET   16'h0000
`define TMC_CTRL1_RESET   16'h0000

`endif

// >>> shared/tmc_pkg.sv
// Purpose: types for the timer module common core
// Assumes: constants live in tmc_defines.svh
// Notes:   timer type selects the width and comparator set
package tmc_pkg;
  typedef enum logic [1:0] {
    TMC_COMPACT,
    TMC_STANDARD,
    TMC_ENHANCED
  } tmc_type_e;

  typedef enum logic [1:0] {
    TMC_MODE_CMP_OUT,
    TMC_MODE_TIMER,
    TMC_MODE_PWM,
    TMC_MODE_SPARE
  } tmc_mode_e;

  typedef enum logic [1:0] {
    TMC_ACT_NONE,
    TMC_ACT_LOW,
    TMC_ACT_HIGH,
    TMC_ACT_TOGGLE
  } tmc_act_e;
endpackage : tmc_pkg

// >>> core/tmc_sync_edge.sv
// Purpose: two-flop synchroniser with edge detection for the pin input
// Assumes: pin is asynchronous to sys_clk
// Notes:   the first flop feeds only the second flop
module tmc_sync_edge (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic pin_async,
  input  wire logic falling_sel,
  output logic      edge_pulse
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= pin_async;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  // active edge polarity chosen by software
  assign edge_pulse = falling_sel ? (last_q & ~sync_q) : (~last_q & sync_q); // RULE6
endmodule : tmc_sync_edge

// >>> verification/tmc_ext_model.sv
// Purpose: far-side source on the external count input
// Assumes: pin is asynchronous to the core clock
// Notes:   gap sets how slowly the edges come
module tmc_ext_model (
  output logic ext_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial ext_pin = 1'b0;
  // each toggle is one rising or one falling edge
  task automatic toggle(input int n, input int gap = 53);
    repeat (n) begin
      #(gap) ext_pin = ~ext_pin;
    end
    #(gap);
  endtask : toggle
endmodule : tmc_ext_model

// >>> verification/tmc_core_asserts.sv
// Purpose: port checks for the timer core
// Assumes: one clock, async active-low reset
// Notes:   shadows ctrl0 and mask to judge count and irq
module tmc_core_asserts
  import tmc_pkg::*;
#(
  parameter tmc_type_e TM_TYPE = TMC_ENHANCED
) (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata_q,
  input wire logic        irq_q,
  input wire logic [1:0]  timer_output_pin_oe_n_q,
  input wire logic [1:0]  timer_pin_select_q
);
  logic        rsv_q;
  logic        seen_q;
  logic        mz_q;
  logic [15:0] cnt_q;
  // ----------------------------------------
  // shadow state
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsv_q  <= 1'b0;
      seen_q <= 1'b0;
      mz_q   <= 1'b1;
      cnt_q  <= 16'h0000;
    end else begin
      if (reg_wr && reg_addr == 4'h0) begin
        rsv_q  <= reg_wdata[2:0] == 3'h5;
        seen_q <= 1'b0;
      end else if ($past(reg_rd && reg_addr == 4'h5) && rsv_q) begin
        seen_q <= 1'b1;
        cnt_q  <= reg_rdata_q;
      end
      if (reg_wr && reg_addr == 4'h7) begin
        mz_q <= reg_wdata[2:0] == 3'h0;
      end
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  oe_match_a: assert property (timer_output_pin_oe_n_q == ~timer_pin_select_q)
    else $error("pin drive enable disagrees with pin select");
  pin_en_wr_a: assert property (reg_wr && reg_addr == 4'h8
    |-> ##2 timer_pin_select_q == $past(reg_wdata[1:0], 2)) else $error("pin enable write lost");
  pin_en_rd_a: assert property (reg_rd && reg_addr == 4'h8
    |=> reg_rdata_q[1:0] == timer_pin_select_q) else $error("pin enable readback");
  sel_cause_a: assert property ($past(rst_n, 2) && $changed(timer_pin_select_q)
    |-> $past(reg_wr && reg_addr == 4'h8, 2)) else $error("pin select moved unasked");
  irq_fall_a: assert property ($fell(irq_q) |-> $past(reg_wr, 2))
    else $error("irq dropped without a write");
  irq_mask_a: assert property (mz_q && $past(mz_q) |-> !irq_q)
    else $error("irq high with all sources masked");
  rsv_hold_a: assert property ($past(reg_rd && reg_addr == 4'h5) && rsv_q && seen_q
    |-> reg_rdata_q == cnt_q) else $error("count moved on reserved clock");
  cmp_width_a: assert property (TM_TYPE != TMC_STANDARD
    && reg_rd && reg_addr == 4'h2 |=> reg_rdata_q[15:10] == 6'h00)
    else $error("compare value wider than ten bits");
endmodule : tmc_core_asserts

bind tmc_core tmc_core_asserts #(.TM_TYPE(TM_TYPE)) chk_u (
  .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .irq_q(irq_q),
  .timer_output_pin_oe_n_q(timer_output_pin_oe_n_q),
  .timer_pin_select_q(timer_pin_select_q)
);

// >>> verification/tb_top.sv
// Purpose: self-checking bench for the timer core
// Assumes: enhanced type, 125 MHz clock
// Notes:   every bus task syncs to an edge first, so calls never collide
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic        hi_tick = 1'b0;
  logic        tb_tick = 1'b0;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic [3:0]  addr    = 4'h0;
  logic [15:0] wd      = 16'h0000;
  logic [15:0] rdq;
  logic        irq;
  logic        ext_pin;
  logic [1:0]  pin;
  logic [1:0]  oe_n;
  logic [1:0]  sel;
  int          n_fail  = 0;
  int          checked = 0;
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) hi_tick <= ~hi_tick;
  tmc_ext_model ext_u (.ext_pin(ext_pin));
  tmc_core dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .high_clk_tick(hi_tick), .time_base_tick(tb_tick),
    .external_count_input(ext_pin), .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr),
    .reg_rd(rd), .reg_rdata_q(rdq), .irq_q(irq), .timer_output_pin_q(pin),
    .timer_output_pin_oe_n_q(oe_n), .timer_pin_select_q(sel)
  );
  // ----------------------------------------
  // bus and compare helpers
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_r(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    addr <= a;
    wd   <= d;
    wr   <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask : wr_r
  task automatic rd_r(input logic [3:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 chk(rdq, e);
  endtask : rd_r
  task automatic nxt(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : nxt
  task automatic wirq;
    for (int i = 0; i < 100; i++) begin
      nxt(1);
      if (irq === 1'b1) break;
    end
    chk({15'h0000, irq}, 16'h0001);
  endtask : wirq
  task automatic summarize;
    if (n_fail == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_pins;
    rd_r(4'h8, 16'h0001);
    chk({12'h000, oe_n, sel}, 16'h0009);
    wr_r(4'h8, 16'h0002);
    nxt(1);
    chk({12'h000, oe_n, sel}, 16'h0006);
    wr_r(4'h8, 16'h0003);
    wr_r(4'h9, 16'h0003);
    nxt(1);
    chk({14'h0000, pin}, 16'h0003);
    wr_r(4'h9, 16'h0000);
  endtask : t_pins
  task automatic t_count;
    wr_r(4'h0, 16'h000D);
    ext_u.toggle(2);
    rd_r(4'h5, 16'h0000);
    nxt(20);
    rd_r(4'h5, 16'h0000);
    wr_r(4'h0, 16'h000E);
    ext_u.toggle(3);
    rd_r(4'h5, 16'h0002);
    wr_r(4'h0, 16'h0016);
    wr_r(4'h0, 16'h001E);
    ext_u.toggle(1);
    rd_r(4'h5, 16'h0001);
  endtask : t_count
  task automatic t_tbase;
    wr_r(4'h0, 16'h0000);
    wr_r(4'h1, 16'h0000);
    wr_r(4'h0, 16'h000C);
    ext_u.toggle(4);
    rd_r(4'h5, 16'h0000);
    repeat (3) begin
      @(posedge sys_clk);
      tb_tick <= 1'b1;
      @(posedge sys_clk);
      tb_tick <= 1'b0;
    end
    rd_r(4'h5, 16'h0003);
    wr_r(4'h0, 16'h0000);
  endtask : t_tbase
  task automatic t_act;
    logic [1:0] act [3] = '{2'h2, 2'h1, 2'h3};
    logic       lvl [3] = '{1'b1, 1'b0, 1'b1};
    wr_r(4'h2, 16'hFFFF);
    rd_r(4'h2, 16'h03FF);
    wr_r(4'h2, 16'h0005);
    wr_r(4'h7, 16'h0001);
    for (int k = 0; k < 3; k++) begin
      wr_r(4'h0, 16'h0000);
      wr_r(4'h6, 16'h0007);
      wr_r(4'h1, {10'h000, 2'h2, act[k], 2'h0});
      wr_r(4'h0, 16'h0009);
      wirq();
      chk({15'h0000, pin[0]}, {15'h0000, lvl[k]});
    end
    wr_r(4'h0, 16'h0000);
    nxt(10);
    rd_r(4'h6, 16'h0007);
    wr_r(4'h6, 16'h0001);
    nxt(1);
    chk({15'h0000, irq}, 16'h0000);
  endtask : t_act
  task automatic t_bp;
    wr_r(4'h6, 16'h0007);
    wr_r(4'h7, 16'h0002);
    wr_r(4'h3, 16'h0003);
    wr_r(4'h4, 16'h0005);
    wr_r(4'h2, 16'h03FF);
    wr_r(4'h1, 16'h0010);
    wr_r(4'h0, 16'h0009);
    wirq();
    nxt(10);
    rd_r(4'h6, 16'h0006);
    wr_r(4'h7, 16'h0000);
    nxt(1);
    chk({15'h0000, irq}, 16'h0000);
    rd_r(4'hF, 16'h0000);
    wr_r(4'h0, 16'h0000);
  endtask : t_bp
  task automatic t_pwm;
    int hi;
    hi = 0;
    wr_r(4'h2, 16'h0002);
    wr_r(4'h4, 16'h0005);
    wr_r(4'h1, 16'h0012);
    wr_r(4'h0, 16'h0009);
    nxt(4);
    for (int i = 0; i < 12; i++) begin
      nxt(1);
      if (pin[0] === 1'b1) hi++;
    end
    chk(16'(hi), 16'h0006);
    wr_r(4'h1, 16'h0011);
    nxt(2);
    chk({15'h0000, pin[0]}, 16'h0000);
    wr_r(4'h0, 16'h0000);
  endtask : t_pwm
  initial begin
    #100us;
    n_fail++;
    summarize();
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_pins();
    t_count();
    t_tbase();
    t_act();
    t_bp();
    t_pwm();
    summarize();
  end
endmodule : tb_top
